// [hdl/ofs_osc_switch.sv]
// internal oscillator block: trim, frequency select and glitch-free handover
// assumes APB master on pclk; oscillators are modelled as pclk-rate phase accumulators
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module ofs_osc_switch
	import ofs_pkg::*;
#(
	parameter int STAB_EDGES = STAB_EDGES_DEF
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	output var  logic              clock_output_pin,
	output var  logic              fast_osc_stable_flag,
	output var  logic [SEL_W-1:0]  active_sel,
	output var  logic              irq
);

	localparam int DW = $clog2(STAB_EDGES + 1);

	function automatic logic [ACC_W-1:0] calc_inc(
		input logic [ACC_W-1:0]  base,
		input logic [TRIM_W-1:0] trim
	);
		logic signed [25:0] sum;
		sum = $signed({2'b00, base}) +
			$signed({2'b00, base >> TRIM_STEP_SHIFT}) * $signed({{20{trim[5]}}, trim});
		return sum[ACC_W-1:0];
	endfunction

	logic [TRIM_W-1:0] trim_q;
	logic [SEL_W-1:0]  sel_q;
	logic [SEL_W-1:0]  cur_q;
	logic [SEL_W-1:0]  tgt_q;
	ofs_state_e        st_q;
	logic [3:0]        cnt_q;
	logic              stable_q;
	logic              dly_run_q;
	logic [DW-1:0]     dly_cnt_q;
	logic [IRQ_W-1:0]  stat_q;
	logic [IRQ_W-1:0]  mask_q;
	logic [ACC_W-1:0]  fast_acc_q;
	logic [ACC_W-1:0]  rc_acc_q;
	logic              fast_prev_q;
	logic [POST_W-1:0] post_q;
	logic [7:0]        lvl_prev_q;
	logic [7:0]        lvl;
	logic [7:0]        fall;
	logic [31:0]       rdata_d;
	logic              mapped;
	logic              setup;
	logic              acc;
	logic              wr;
	logic              rd;
	logic              done_evt;
	logic              stab_evt;
	logic [IRQ_W-1:0]  stat_d;

	// ---------------- oscillator models ----------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_acc_q  <= '0;
			rc_acc_q    <= '0;
			fast_prev_q <= 1'b0;
			post_q      <= '0;
			lvl_prev_q  <= '0;
		end else begin
			fast_acc_q  <= fast_acc_q + calc_inc(FAST_INC_BASE, trim_q);
			rc_acc_q    <= rc_acc_q + calc_inc(RC_INC_BASE, trim_q);
			fast_prev_q <= fast_acc_q[ACC_W-1];
			// postscaler advances on each rising edge of the fast source
			if (fast_acc_q[ACC_W-1] && !fast_prev_q) begin
				post_q <= post_q + POST_W'(1);
			end
			lvl_prev_q <= lvl;
		end
	end

	// level of each of the eight selectable sources, indexed by select code
	always_comb begin
		lvl    = '0;
		lvl[0] = rc_acc_q[ACC_W-1];
		lvl[7] = fast_acc_q[ACC_W-1];
		for (int k = 1; k < 7; k++) begin
			lvl[k] = post_q[6-k];
		end
		fall = lvl_prev_q & ~lvl;
	end

	// ---------------- APB slave ----------------
	assign setup = psel && !penable;
	assign acc   = psel && penable && pready;
	assign wr    = acc && pwrite;
	assign rd    = acc && !pwrite;

	always_comb begin
		rdata_d = '0;
		mapped  = 1'b1;
		case (paddr)
			ADDR_OSC_CTRL: begin
				rdata_d[SEL_LSB+SEL_W-1:SEL_LSB] = sel_q;
				rdata_d[STABLE_BIT]              = stable_q;
			end
			ADDR_OSC_TRIM: rdata_d[TRIM_W-1:0] = trim_q;
			ADDR_IRQ_STAT: rdata_d[IRQ_W-1:0] = stat_q;
			ADDR_IRQ_MASK: rdata_d[IRQ_W-1:0] = mask_q;
			default:       mapped = 1'b0;
		endcase
	end

	// zero-wait answer: pready rises in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				prdata <= rdata_d;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sel_q  <= SEL_RC;
			trim_q <= TRIM_RESET;
			mask_q <= '0;
		end else if (wr) begin
			case (paddr)
				ADDR_OSC_CTRL: sel_q <= pwdata[SEL_LSB+SEL_W-1:SEL_LSB];
				ADDR_OSC_TRIM: trim_q <= pwdata[TRIM_W-1:0];
				ADDR_IRQ_MASK: mask_q <= pwdata[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// ---------------- handover ----------------
	assign done_evt = (st_q == ST_HOLD) && (sel_q == tgt_q) && fall[tgt_q] &&
		(cnt_q == 4'(HANDOVER_EDGES - 1));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q             <= ST_RUN;
			cur_q            <= SEL_RC;
			tgt_q            <= SEL_RC;
			cnt_q            <= '0;
			clock_output_pin <= 1'b0;
		end else begin
			case (st_q)
				ST_RUN: begin
					clock_output_pin <= lvl[cur_q];
					if (sel_q != cur_q) begin
						tgt_q <= sel_q;
						st_q  <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					tgt_q <= sel_q;
					if (fall[cur_q]) begin
						clock_output_pin <= 1'b0;
						cnt_q            <= '0;
						st_q             <= ST_HOLD;
					end else begin
						clock_output_pin <= lvl[cur_q];
					end
				end
				ST_HOLD: begin
					clock_output_pin <= 1'b0;
					// a fresh write during the hold restarts the edge count
					if (sel_q != tgt_q) begin
						tgt_q <= sel_q;
						cnt_q <= '0;
					end else if (done_evt) begin
						cur_q <= tgt_q;
						st_q  <= ST_RUN;
					end else if (fall[tgt_q]) begin
						cnt_q <= cnt_q + 4'd1;
					end
				end
				default: st_q <= ST_RUN;
			endcase
		end
	end

	// ---------------- stabilisation ----------------
	// a handover between fast codes leaves the delay running; only a return to rc cancels it
	assign stab_evt = dly_run_q && fall[SEL_RC] && (dly_cnt_q == DW'(STAB_EDGES - 1)) &&
		!(done_evt && tgt_q == SEL_RC);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stable_q  <= 1'b0;
			dly_run_q <= 1'b0;
			dly_cnt_q <= '0;
		end else if (done_evt && cur_q == SEL_RC && tgt_q != SEL_RC) begin
			stable_q  <= 1'b0;
			dly_run_q <= 1'b1;
			dly_cnt_q <= '0;
		end else if (done_evt && tgt_q == SEL_RC) begin
			// fast source is idle on the RC clock, so it no longer counts as stable
			stable_q  <= 1'b0;
			dly_run_q <= 1'b0;
		end else if (dly_run_q && fall[SEL_RC]) begin
			if (stab_evt) begin
				stable_q  <= 1'b1;
				dly_run_q <= 1'b0;
			end else begin
				dly_cnt_q <= dly_cnt_q + DW'(1);
			end
		end
	end

	// ---------------- events and interrupt ----------------
	always_comb begin
		stat_d = stat_q;
		// only bits that were returned are cleared, so a later event survives
		if (rd && paddr == ADDR_IRQ_STAT) begin
			stat_d = stat_d & ~prdata[IRQ_W-1:0];
		end
		stat_d[EVT_SWITCH] = stat_d[EVT_SWITCH] | done_evt;
		stat_d[EVT_STABLE] = stat_d[EVT_STABLE] | stab_evt;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_q               <= '0;
			irq                  <= 1'b0;
			fast_osc_stable_flag <= 1'b0;
			active_sel           <= SEL_RC;
		end else begin
			stat_q               <= stat_d;
			irq                  <= |(stat_q & mask_q);
			fast_osc_stable_flag <= stable_q;
			active_sel           <= cur_q;
		end
	end

	// ---------------- checks ----------------
	trim_upper_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == ADDR_OSC_TRIM) |-> (prdata[31:TRIM_W] == '0))
		else $error("trim upper bits not zero");

	ctrl_unused_a: assert property (@(posedge pclk) disable iff (!presetn)
		(rd && paddr == ADDR_OSC_CTRL) |->
		(prdata[7] == 1'b0 && prdata[3] == 1'b0 && prdata[1:0] == 2'b00))
		else $error("control unused bits not zero");

	ctrl_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && paddr == ADDR_OSC_CTRL) |=> (prdata[STABLE_BIT] == $past(stable_q)))
		else $error("stable flag read wrong");

	sel_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == ADDR_OSC_CTRL) |=>
		(sel_q == $past(pwdata[SEL_LSB+SEL_W-1:SEL_LSB])))
		else $error("select write not taken");

	hold_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_WAIT && fall[cur_q]) |=> (!clock_output_pin && st_q == ST_HOLD))
		else $error("clock not held low after falling edge");

	edge_count_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_HOLD && sel_q == tgt_q && fall[tgt_q] && cnt_q != 4'(HANDOVER_EDGES - 1))
		|=> (st_q == ST_HOLD && !clock_output_pin))
		else $error("handover before eight edges");

	connect_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt |=> (st_q == ST_RUN && cur_q == $past(tgt_q)))
		else $error("new source not connected");

	stab_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done_evt && cur_q == SEL_RC && tgt_q != SEL_RC) |=>
		(!stable_q && dly_run_q && dly_cnt_q == '0))
		else $error("delay not started on leaving rc");

	stab_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		stab_evt |=> (stable_q && !dly_run_q))
		else $error("stable flag not set at delay end");

	keep_stable_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done_evt && cur_q != SEL_RC && tgt_q != SEL_RC && stable_q) |=> stable_q)
		else $error("stable flag dropped between fast codes");

	to_rc_a: assert property (@(posedge pclk) disable iff (!presetn)
		(done_evt && tgt_q == SEL_RC) |=> (!dly_run_q && cur_q == SEL_RC))
		else $error("delay applied on switch to rc");

	rc_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && cur_q == SEL_RC) |=> (clock_output_pin == $past(rc_acc_q[ACC_W-1])))
		else $error("rc source not routed to clock output");

	fast_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && cur_q == SEL_FAST) |=> (clock_output_pin == $past(fast_acc_q[ACC_W-1])))
		else $error("fast source not routed to clock output");

	half_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && cur_q == 3'h6) |=> (clock_output_pin == $past(post_q[0])))
		else $error("divide by two not routed");

	slow_route_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && cur_q == 3'h1) |=> (clock_output_pin == $past(post_q[POST_W-1])))
		else $error("divide by sixty-four not routed");

	trim_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		(wr && paddr == ADDR_OSC_TRIM) |=> (trim_q == $past(pwdata[TRIM_W-1:0])))
		else $error("trim write not taken");

	sel_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		!(wr && paddr == ADDR_OSC_CTRL) |=> $stable(sel_q))
		else $error("select changed without a write");

	switch_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_RUN && sel_q != cur_q) |=> (st_q == ST_WAIT && tgt_q == $past(sel_q)))
		else $error("handover not started after select write");

	wait_pass_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_WAIT && !fall[cur_q]) |=> (st_q == ST_WAIT && clock_output_pin == $past(lvl[cur_q])))
		else $error("current clock not passed while waiting");

	hold_out_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_HOLD) |=> !clock_output_pin)
		else $error("clock output not low during hold");

	count_range_a: assert property (@(posedge pclk) disable iff (!presetn)
		(st_q == ST_HOLD) |-> (cnt_q < 4'(HANDOVER_EDGES)))
		else $error("edge count out of range");

	flag_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (fast_osc_stable_flag == $past(stable_q)))
		else $error("stable flag output wrong");

	rc_no_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
		(cur_q == SEL_RC) |-> !dly_run_q)
		else $error("delay running on rc source");

	delay_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		dly_run_q |-> (dly_cnt_q < DW'(STAB_EDGES)))
		else $error("delay counter past its end");

	stable_low_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!stab_evt && !stable_q) |=> !stable_q)
		else $error("stable flag set before delay end");

	ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held longer than one cycle");

	err_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error without ready");

	switch_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
		done_evt |=> stat_q[EVT_SWITCH])
		else $error("handover event not recorded");

	stable_evt_a: assert property (@(posedge pclk) disable iff (!presetn)
		stab_evt |=> stat_q[EVT_STABLE])
		else $error("delay expiry event not recorded");

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		1'b1 |=> (irq == $past(|(stat_q & mask_q))))
		else $error("interrupt level wrong");

endmodule // ofs_osc_switch

`default_nettype wire

// [include/ofs_pkg.sv]
// constants, register map and types for the internal oscillator frequency switch
// assumes a 40 MHz pclk and 32-bit APB with one register per aligned word
// How it works
// - trim register bits 7 and 6 always read as zero.
// - six-bit trim is signed; 011111 fastest, 000000 centre, 100000 slowest.
// - select 111 drives the 8 MHz source direct; 000 the 31.25 kHz source.
// - codes 110 to 001 pick the fast source divided 2, 4, 8, 16, 32, 64.
// - a select write changes the requested multiplexer input at once.
// - select writes are accepted at any time, whatever source is running.
// - leaving 000 starts a stabilisation delay of about 4 ms; code keeps running.
// - leaving 000 clears the stable flag; it sets again when the delay expires.
// - between two non-000 codes no delay; the stable flag stays as it was.
// - every switch waits for a falling edge of the current clock, then holds low.
// - while low, count eight falling edges of the new clock, then connect it.
// - a switch down to 000 ends after the eight-edge handover, with no delay.
// - control bit 2 is the read-only stable flag, reset to zero.
// - control bits 7, 3, 1 and 0 always read as zero.
// - trim moves both sources over about +/-12.5 percent, equal steps.
package ofs_pkg;

	// timing
	localparam int PCLK_PERIOD_NS = 25;
	localparam int FAST_PERIOD_NS = 125;
	localparam int RC_PERIOD_NS   = 32000;
	localparam int STAB_TIME_NS   = 4000000;
	localparam int STAB_EDGES_DEF = (STAB_TIME_NS + RC_PERIOD_NS - 1) / RC_PERIOD_NS;
	localparam int HANDOVER_EDGES = 8;

	// oscillator models: phase accumulators stepped once per pclk
	localparam int          ACC_W          = 24;
	localparam logic [63:0] ACC_ONE        = 64'h0000_0000_0100_0000;
	localparam logic [23:0] FAST_INC_BASE  =
		24'(ACC_ONE * 64'(PCLK_PERIOD_NS) / 64'(FAST_PERIOD_NS));
	localparam logic [23:0] RC_INC_BASE    =
		24'(ACC_ONE * 64'(PCLK_PERIOD_NS) / 64'(RC_PERIOD_NS));
	// 12.5 percent over 32 steps is 1/256 per step
	localparam int          TRIM_STEP_SHIFT = 8;
	localparam int          POST_W          = 6;

	// register indices as printed, byte address is four times the index
	localparam int           ADDR_W        = 12;
	localparam logic [7:0]   OSC_CTRL_IDX  = 8'h8f;
	localparam logic [7:0]   OSC_TRIM_IDX  = 8'h90;
	localparam logic [7:0]   IRQ_STAT_IDX  = 8'h91;
	localparam logic [7:0]   IRQ_MASK_IDX  = 8'h92;
	localparam logic [11:0]  ADDR_OSC_CTRL = {2'h0, OSC_CTRL_IDX, 2'h0};
	localparam logic [11:0]  ADDR_OSC_TRIM = {2'h0, OSC_TRIM_IDX, 2'h0};
	localparam logic [11:0]  ADDR_IRQ_STAT = {2'h0, IRQ_STAT_IDX, 2'h0};
	localparam logic [11:0]  ADDR_IRQ_MASK = {2'h0, IRQ_MASK_IDX, 2'h0};

	// fields
	localparam int         TRIM_W     = 6;
	localparam int         SEL_LSB    = 4;
	localparam int         SEL_W      = 3;
	localparam int         STABLE_BIT = 2;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam int         IRQ_W      = 2;
	localparam int         EVT_SWITCH = 0;
	localparam int         EVT_STABLE = 1;

	typedef enum logic [2:0] {
		SEL_RC   = 3'b000,
		SEL_FAST = 3'b111
	} ofs_sel_e;

	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_WAIT = 2'b01,
		ST_HOLD = 2'b10
	} ofs_state_e;

endpackage

// [dv/ofs_sw_model.sv]
// apb master model standing in for the processor software
// assumes pclk from the bench; a slave that never answers is cut off after 64 cycles
`timescale 1ns/1ps
`default_nettype none
module ofs_sw_model
	import ofs_pkg::*;
(
	input  wire logic              pclk,
	output var  logic              psel,
	output var  logic              penable,
	output var  logic              pwrite,
	output var  logic [ADDR_W-1:0] paddr,
	output var  logic [31:0]       pwdata,
	input  wire logic [31:0]       prdata,
	input  wire logic              pready,
	input  wire logic              pslverr
);
	int hangs = 0;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
	end
	// idle address and data are inverted so the slave cannot lean on stale values
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (i = 0; i < 64; i++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (i == 64) hangs++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		paddr <= ~a;
		pwdata <= ~d;
	endtask
	task automatic poll_stable(output logic ok);
		logic [31:0] q;
		logic        e;
		ok = 1'b0;
		for (int i = 0; i < 4000 && !ok; i++) begin
			xfer(1'b0, ADDR_OSC_CTRL, 32'h0, q, e);
			ok = q[STABLE_BIT];
		end
	endtask
endmodule // ofs_sw_model
`default_nettype wire

// [dv/internal_osc_freq_switch_tb.sv]
// self-checking bench for the oscillator switch: registers, handover, periods
// assumes ofs_pkg and the apb model ofs_sw_model; stabilisation shortened to 4 edges
`timescale 1ns/1ps
`default_nettype none
module internal_osc_freq_switch_tb;
	import ofs_pkg::*;
	localparam int STAB = 4;
	localparam int FP   = FAST_PERIOD_NS / PCLK_PERIOD_NS;
	localparam int RP   = RC_PERIOD_NS / PCLK_PERIOD_NS;
	logic              pclk = 1'b0;
	logic              presetn = 1'b0;
	logic              psel, penable, pwrite, pready, pslverr, clk_o, stab, irq, drop, e;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, q;
	logic [SEL_W-1:0]  asel;
	int                n_mismatch = 0, samples_checked = 0, cyc = 0, low, r, code, t0;
	always #(PCLK_PERIOD_NS / 2.0) pclk = ~pclk;
	always @(posedge pclk) cyc <= cyc + 1;
	ofs_osc_switch #(.STAB_EDGES(STAB)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .clock_output_pin(clk_o),
		.fast_osc_stable_flag(stab), .active_sel(asel), .irq(irq));
	ofs_sw_model SW (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic conclude();
		n_mismatch += SW.hangs;
		$display("checked %0d mismatched %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
		SW.xfer(1'b1, a, d, q, e);
		if (SW.hangs != 0) conclude();
	endtask
	task automatic rd_chk(input string nm, input logic [ADDR_W-1:0] a, input logic [31:0] x);
		SW.xfer(1'b0, a, 32'h0, q, e);
		if (SW.hangs != 0) conclude();
		check(nm, q, x);
	endtask
	// low ends as the run of low pclk just before the new code lands
	task automatic wait_sel(input logic [2:0] c);
		int i;
		low = 0;
		drop = 1'b0;
		for (i = 0; i < 20000; i++) begin
			@(posedge pclk);
			if (asel === c) break;
			low = (clk_o === 1'b0) ? low + 1 : 0;
			if (stab !== 1'b1) drop = 1'b1;
		end
		if (i == 20000) begin
			n_mismatch++;
			conclude();
		end
	endtask
	function automatic int exp_per(input int c, input int n, input logic [5:0] t);
		return n * ((c == 0) ? RP : (FP << (7 - c))) * 256 / (256 + int'($signed(t)));
	endfunction
	// the oscillators jitter by a pclk, so periods are compared within a tolerance
	task automatic per_chk(input int n, input int x, input int tol);
		int   k, t;
		logic p;
		k = 0;
		t = 0;
		p = 1'b1;
		for (int i = 0; i < 20000 && k <= n; i++) begin
			@(posedge pclk);
			if (k > 0) t++;
			k += int'(clk_o === 1'b1 && p === 1'b0);
			p = clk_o;
		end
		check("period", 32'(t - x <= tol && x - t <= tol), 32'h1);
	endtask
	initial begin
		r = $urandom(18621);
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk("ctrl", ADDR_OSC_CTRL, 32'h0);
		rd_chk("trim", ADDR_OSC_TRIM, 32'h0);
		rd_chk("mask", ADDR_IRQ_MASK, 32'h0);
		$display("test reset done");
		repeat (4) begin
			r = $urandom;
			wr(ADDR_OSC_TRIM, r);
			rd_chk("trim", ADDR_OSC_TRIM, r & 32'h3f);
		end
		wr(ADDR_OSC_TRIM, 32'h0);
		rd_chk("unmapped", 12'h000, 32'h0);
		check("unmapped err", e, 1'b1);
		$display("test registers done");
		wr(ADDR_OSC_CTRL, 32'hff);
		rd_chk("ctrl", ADDR_OSC_CTRL, 32'h70);
		wr(ADDR_OSC_CTRL, 32'h50);
		wait_sel(3'd5);
		check("hold", 32'(low >= 7 * (FP << 2)), 32'h1);
		check("stable", stab, 1'b0);
		check("irq masked", irq, 1'b0);
		t0 = cyc;
		SW.poll_stable(e);
		check("stable set", e, 1'b1);
		if (e !== 1'b1) conclude();
		check("delay", 32'(cyc - t0 >= (STAB - 1) * RP - 64), 32'h1);
		rd_chk("ctrl", ADDR_OSC_CTRL, 32'h54);
		wr(ADDR_IRQ_MASK, 32'h3);
		repeat (2) @(posedge pclk);
		check("irq", irq, 1'b1);
		rd_chk("status", ADDR_IRQ_STAT, 32'h3);
		repeat (2) @(posedge pclk);
		check("irq clear", irq, 1'b0);
		$display("test leave rc done");
		r = $urandom_range(6);
		for (int i = 0; i < 7; i++) begin
			code = (i + r) % 7 + 1;
			if (asel !== 3'(code)) begin
				wr(ADDR_OSC_CTRL, 32'(code) << 4);
				wait_sel(3'(code));
				check("hold", 32'(low >= 7 * (FP << (7 - code))), 32'h1);
				check("no drop", drop, 1'b0);
			end
			per_chk(2, exp_per(code, 2, 6'h0), 1);
		end
		wr(ADDR_OSC_CTRL, 32'h70);
		wait_sel(3'd7);
		for (int k = 0; k < 2; k++) begin
			r = k ? 32'h20 : 32'h1f;
			wr(ADDR_OSC_TRIM, r);
			per_chk(64, exp_per(7, 64, 6'(r)), 3);
		end
		wr(ADDR_OSC_TRIM, 32'h0);
		$display("test fast codes done");
		wr(ADDR_OSC_CTRL, 32'h0);
		wait_sel(3'd0);
		check("stable", stab, 1'b0);
		check("irq", irq, 1'b1);
		per_chk(1, exp_per(0, 1, 6'h0), 2);
		rd_chk("status", ADDR_IRQ_STAT, 32'h1);
		$display("test back to rc done");
		conclude();
	end
endmodule // internal_osc_freq_switch_tb
`default_nettype wire
